/* File: common/rmrb_pkg.sv */
// Constants, layouts and state carriers of the runtime miscellaneous register bank.
// ====================================================================
package rmrb_pkg;

  // ====================================================================
  // Register offsets and reset values.
  localparam logic [7:0] RMRB_FAN_ONE_COUNT_OFS = 8'h59;
  localparam logic [7:0] RMRB_FAN_TWO_COUNT_OFS = 8'h5A;
  localparam logic [7:0] RMRB_FAN_ONE_START_OFS = 8'h5B;
  localparam logic [7:0] RMRB_FAN_TWO_START_OFS = 8'h5C;
  localparam logic [7:0] RMRB_LAMP_ONE_OFS = 8'h5D;
  localparam logic [7:0] RMRB_LAMP_TWO_OFS = 8'h5E;
  localparam logic [7:0] RMRB_SCAN_OFS = 8'h5F;
  localparam logic [7:0] RMRB_RSVD_LO_OFS = 8'h60;
  localparam logic [7:0] RMRB_RSVD_HI_OFS = 8'h7F;
  localparam logic [7:0] RMRB_REG_RESET = 8'h00;
  localparam logic [1:0] RMRB_SETTLE_PULSES = 2'h2;

  // ====================================================================
  // Lamp control encodings.
  localparam logic [1:0] RMRB_LAMP_OFF = 2'h0;
  localparam logic [1:0] RMRB_LAMP_HALF = 2'h1;
  localparam logic [1:0] RMRB_LAMP_QUARTER = 2'h2;
  localparam logic [1:0] RMRB_LAMP_ON = 2'h3;

  // ====================================================================
  // Timing: clock rate and the half-second blink step.
  localparam longint RMRB_CLK_HZ = 200000000;
  localparam longint RMRB_HALF_SEC_MS = 500;
  localparam int RMRB_HALF_SEC_CYCLES = int'((RMRB_CLK_HZ * RMRB_HALF_SEC_MS) / 1000);
  localparam int RMRB_TACH_TICK_CYCLES = 200;

  // ====================================================================
  // Event pins: index 0..2 standby pins a, b, c; index 3 ring shared pin.
  localparam int RMRB_EVT_PINS = 4;
  localparam logic [3:0] RMRB_WAKE_STS_POR = 4'h7;
  localparam logic [3:0] RMRB_MGMT_STS_POR = 4'h3;
  localparam logic [3:0] RMRB_MISC_STS_POR = 4'h0;

  // ====================================================================
  // Register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rmrb_bus_req_t;

  // Whole state of the bank.
  typedef struct packed {
    logic [7:0] rdata;
    logic [1:0][7:0] start;
    logic [1:0][7:0] cnt;
    logic [1:0][7:0] reading;
    logic [1:0][1:0] settle;
    logic [1:0] tach_prev;
    logic [15:0] tach_div;
    logic [1:0][1:0] lamp_ctl;
    logic [7:0] scan;
    logic [31:0] half_div;
    logic [1:0] phase;
    logic [1:0] lamp;
    logic [3:0] evt_prev;
    logic [3:0] wake_sts;
    logic [3:0] mgmt_sts;
    logic [3:0] misc_sts;
    logic por_pend;
    logic [3:0] gp_level;
    logic [3:0] gp_is_out;
    logic mgmt_o;
    logic mgmt_oe_n;
    logic fdc_o;
    logic fdc_oe_n;
    logic kbc7_a;
    logic kbc7_b;
    logic irtx_en;
  } rmrb_state_t;

endpackage : rmrb_pkg

/* File: hw/rmrb_bank.sv */
// Runtime miscellaneous register bank: fan start values, lamps, scan code, pin events.
`timescale 1ns/1ps
module rmrb_bank
  import rmrb_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = RMRB_HALF_SEC_CYCLES,
  parameter int TACH_TICK_CYCLES = RMRB_TACH_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Register port.
  input wire rmrb_bus_req_t bus_req_in,
  output logic [7:0] bus_rdata_out,
  // Fan tachometers.
  input wire logic [1:0] fan_tach_in,
  output logic [1:0] fan_count_valid_out,
  // Status lamps.
  output logic status_lamp_one_out,
  output logic status_lamp_two_out,
  // Event pins and their configuration.
  input wire logic [3:0] evt_pin_in,
  input wire logic [3:0] evt_invert_in,
  input wire logic [3:0] either_edge_event_in,
  input wire logic [3:0] evt_pin_is_input_in,
  input wire logic [3:0] evt_out_level_in,
  input wire logic [3:0] wake_status_clear_in,
  input wire logic [3:0] mgmt_status_clear_in,
  input wire logic [3:0] misc_status_clear_in,
  output logic [3:0] wake_status_out,
  output logic [3:0] mgmt_status_out,
  output logic [3:0] misc_status_out,
  output logic [3:0] evt_pin_level_out,
  output logic [3:0] evt_pin_is_out_out,
  // Management interrupt pin.
  input wire logic [3:0] mgmt_enable_reg_two_in,
  input wire logic mgmt_global_enable_in,
  input wire logic mgmt_open_drain_in,
  output logic mgmt_interrupt_o_out,
  output logic mgmt_interrupt_oe_n_out,
  // Floppy-shared pin.
  input wire logic fdc_select_in,
  input wire logic drive_density_function_in,
  input wire logic [7:6] floppy_mode_reg_in,
  input wire logic gpio_ctl_bit7_in,
  input wire logic gpio_level_in,
  output logic fdc_pin_o_out,
  output logic fdc_pin_oe_n_out,
  // Alternate function routing.
  input wire logic kbc_port_bit7_sel_a_in,
  input wire logic kbc_port_bit7_sel_b_in,
  input wire logic infrared_loc_mux_in,
  input wire logic infrared_tx_alt_sel_in,
  output logic shared_pin_a_kbc7_out,
  output logic shared_pin_b_kbc7_out,
  output logic infrared_tx_alt_en_out
);

  // ====================================================================
  // Address decode used by the read path only; writes to the reserved range fall to the default.
  function automatic logic is_reserved(input logic [7:0] a);
    is_reserved = (a >= RMRB_RSVD_LO_OFS) && (a <= RMRB_RSVD_HI_OFS);
  endfunction : is_reserved

  // Lamp output for a control code at a given half-second phase.
  function automatic logic lamp_level(input logic [1:0] code, input logic [1:0] ph);
    case (code)
      RMRB_LAMP_OFF: lamp_level = 1'b0;
      RMRB_LAMP_HALF: lamp_level = ~ph[0];
      RMRB_LAMP_QUARTER: lamp_level = (ph == 2'h0);
      RMRB_LAMP_ON: lamp_level = 1'b1;
      default: lamp_level = 1'b0;
    endcase
  endfunction : lamp_level

  rmrb_state_t st;
  rmrb_state_t next_st;
  logic tach_tick;
  logic half_tick;
  logic [3:0] evt_lvl;
  logic [3:0] evt_hit;
  logic mgmt_active;

  // ====================================================================
  // Free-running dividers; both are ticks of the same clock, so lamp phases are
  // exact multiples of the half second with no drift between the two lamps.
  assign tach_tick = (st.tach_div == 16'(TACH_TICK_CYCLES - 1));
  assign half_tick = (st.half_div == 32'(HALF_SEC_CYCLES - 1));

  // Inversion applies only to single-edge detection; either-edge ignores it.
  assign evt_lvl = evt_pin_in ^ (evt_invert_in & ~either_edge_event_in);
  assign evt_hit = either_edge_event_in & (evt_pin_in ^ st.evt_prev)
                 | ~either_edge_event_in & evt_lvl & ~(st.evt_prev ^ (evt_invert_in & ~either_edge_event_in));

  assign mgmt_active = (|(st.mgmt_sts & mgmt_enable_reg_two_in)) & mgmt_global_enable_in;

  // ====================================================================
  // Next-state logic for the whole bank.
  always_comb begin
    next_st = st;
    next_st.tach_div = tach_tick ? 16'h0000 : st.tach_div + 16'h0001;
    next_st.half_div = half_tick ? 32'h0000_0000 : st.half_div + 32'h0000_0001;
    if (half_tick) begin
      next_st.phase = st.phase + 2'h1;
    end

    // Read data stand in the cycle after the strobe only.
    next_st.rdata = 8'h00;
    if (bus_req_in.rd) begin
      case (bus_req_in.addr)
        RMRB_FAN_ONE_COUNT_OFS: next_st.rdata = st.reading[0];
        RMRB_FAN_TWO_COUNT_OFS: next_st.rdata = st.reading[1];
        RMRB_FAN_ONE_START_OFS: next_st.rdata = st.start[0];
        RMRB_FAN_TWO_START_OFS: next_st.rdata = st.start[1];
        RMRB_LAMP_ONE_OFS: next_st.rdata = {6'h00, st.lamp_ctl[0]};
        RMRB_LAMP_TWO_OFS: next_st.rdata = {6'h00, st.lamp_ctl[1]};
        RMRB_SCAN_OFS: next_st.rdata = st.scan;
        default: next_st.rdata = 8'h00;
      endcase
      if (is_reserved(bus_req_in.addr)) begin
        next_st.rdata = 8'h00;
      end
    end

    // Tachometers: count ticks from the start value; each fan pulse latches the
    // final count and restarts from the start value.
    for (int f = 0; f < 2; f++) begin
      next_st.tach_prev[f] = fan_tach_in[f];
      if (tach_tick && st.cnt[f] != 8'hFF) begin
        next_st.cnt[f] = st.cnt[f] + 8'h01;
      end
      if (fan_tach_in[f] && !st.tach_prev[f]) begin
        next_st.reading[f] = st.cnt[f];
        next_st.cnt[f] = st.start[f];
        if (st.settle[f] != 2'h0) begin
          next_st.settle[f] = st.settle[f] - 2'h1;
        end
      end
    end

    // Register writes; a start write restarts the count beside storing it.
    if (bus_req_in.wr) begin
      case (bus_req_in.addr)
        RMRB_FAN_ONE_START_OFS: begin
          next_st.start[0] = bus_req_in.wdata;
          next_st.cnt[0] = bus_req_in.wdata;
          next_st.settle[0] = RMRB_SETTLE_PULSES;
        end
        RMRB_FAN_TWO_START_OFS: begin
          next_st.start[1] = bus_req_in.wdata;
          next_st.cnt[1] = bus_req_in.wdata;
          next_st.settle[1] = RMRB_SETTLE_PULSES;
        end
        RMRB_LAMP_ONE_OFS: next_st.lamp_ctl[0] = bus_req_in.wdata[1:0];
        RMRB_LAMP_TWO_OFS: next_st.lamp_ctl[1] = bus_req_in.wdata[1:0];
        RMRB_SCAN_OFS: next_st.scan = bus_req_in.wdata;
        default: next_st.scan = st.scan;
      endcase
    end

    next_st.lamp[0] = lamp_level(st.lamp_ctl[0], st.phase);
    next_st.lamp[1] = lamp_level(st.lamp_ctl[1], st.phase);

    // Event status: clear first, then set, so a same-cycle event is kept.
    next_st.evt_prev = evt_pin_in;
    next_st.wake_sts = (st.wake_sts & ~wake_status_clear_in) | evt_hit;
    next_st.mgmt_sts = (st.mgmt_sts & ~mgmt_status_clear_in) | evt_hit;
    next_st.misc_sts = (st.misc_sts & ~misc_status_clear_in) | evt_hit;

    // Power-on status only stands for pins that are inputs; the strap-like
    // configuration is looked at once, in the first cycle after release.
    next_st.por_pend = 1'b0;
    if (st.por_pend) begin
      next_st.wake_sts = next_st.wake_sts & (evt_pin_is_input_in | evt_hit);
      next_st.mgmt_sts = next_st.mgmt_sts & (evt_pin_is_input_in | evt_hit);
    end

    // Pins hold output-low until the reset settles, then follow configuration.
    next_st.gp_level = evt_out_level_in;
    next_st.gp_is_out = ~evt_pin_is_input_in;

    // Management pin: active low; open-drain floats when idle.
    next_st.mgmt_o = ~mgmt_active;
    next_st.mgmt_oe_n = mgmt_open_drain_in & ~mgmt_active;

    // Floppy pin: mode bit 6 picks the output type, mode bit 7 inverts the level.
    if (fdc_select_in) begin
      next_st.fdc_o = drive_density_function_in ^ floppy_mode_reg_in[7];
      next_st.fdc_oe_n = floppy_mode_reg_in[6] & next_st.fdc_o;
    end else begin
      next_st.fdc_o = gpio_level_in;
      next_st.fdc_oe_n = gpio_ctl_bit7_in & gpio_level_in;
    end

    next_st.kbc7_b = kbc_port_bit7_sel_b_in;
    next_st.kbc7_a = kbc_port_bit7_sel_a_in & ~kbc_port_bit7_sel_b_in;
    next_st.irtx_en = infrared_tx_alt_sel_in & infrared_loc_mux_in;
  end

  // ====================================================================
  // State register; every field resets to a constant.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
      st.start <= {RMRB_REG_RESET, RMRB_REG_RESET};
      st.scan <= RMRB_REG_RESET;
      st.wake_sts <= RMRB_WAKE_STS_POR;
      st.mgmt_sts <= RMRB_MGMT_STS_POR;
      st.misc_sts <= RMRB_MISC_STS_POR;
      st.por_pend <= 1'b1;
      st.gp_is_out <= 4'hF;
      st.gp_level <= 4'h0;
      st.mgmt_o <= 1'b1;
      st.mgmt_oe_n <= 1'b1;
      st.fdc_o <= 1'b1;
      st.fdc_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ====================================================================
  // Outputs, from flip-flops except the fan valid flags, which are decoded from the settle counters.
  assign bus_rdata_out = st.rdata;
  assign fan_count_valid_out = {st.settle[1] == 2'h0, st.settle[0] == 2'h0};
  assign status_lamp_one_out = st.lamp[0];
  assign status_lamp_two_out = st.lamp[1];
  assign wake_status_out = st.wake_sts;
  assign mgmt_status_out = st.mgmt_sts;
  assign misc_status_out = st.misc_sts;
  assign evt_pin_level_out = st.gp_level;
  assign evt_pin_is_out_out = st.gp_is_out;
  assign mgmt_interrupt_o_out = st.mgmt_o;
  assign mgmt_interrupt_oe_n_out = st.mgmt_oe_n;
  assign fdc_pin_o_out = st.fdc_o;
  assign fdc_pin_oe_n_out = st.fdc_oe_n;
  assign shared_pin_a_kbc7_out = st.kbc7_a;
  assign shared_pin_b_kbc7_out = st.kbc7_b;
  assign infrared_tx_alt_en_out = st.irtx_en;

  // ====================================================================
  // Checks.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_start_one_write;
    bus_req_in.wr && bus_req_in.addr == RMRB_FAN_ONE_START_OFS && !fan_tach_in[0];
  endsequence

  a_start_one_hold: assert property (s_start_one_write |=> st.start[0] == $past(bus_req_in.wdata)
    && st.cnt[0] == $past(bus_req_in.wdata) && st.settle[0] == 2'h2)
    else $error("fan one start write not taken");
  a_start_two_hold: assert property (bus_req_in.wr && bus_req_in.addr == RMRB_FAN_TWO_START_OFS
    |=> st.start[1] == $past(bus_req_in.wdata) && st.cnt[1] == $past(bus_req_in.wdata))
    else $error("fan two start write not taken");
  a_start_read_back: assert property (s_start_one_write ##1 (bus_req_in.rd
    && bus_req_in.addr == RMRB_FAN_ONE_START_OFS && !bus_req_in.wr) |=> bus_rdata_out == $past(st.start[0], 1))
    else $error("fan one start read back wrong");
  a_tach_latch: assert property ($rose(fan_tach_in[0]) && !bus_req_in.wr
    |=> st.reading[0] == $past(st.cnt[0]) && st.cnt[0] == $past(st.start[0]))
    else $error("tach reading not latched on pulse");
  a_settle_count: assert property (s_start_one_write ##1 (!bus_req_in.wr && !fan_tach_in[0])[*2]
    |-> !fan_count_valid_out[0])
    else $error("count marked valid too early");
  a_lamp_steady: assert property (st.lamp_ctl[0] == RMRB_LAMP_OFF && $past(st.lamp_ctl[0]) == RMRB_LAMP_OFF
    |-> !status_lamp_one_out)
    else $error("lamp one lit while off");
  a_lamp_on: assert property (st.lamp_ctl[1] == RMRB_LAMP_ON && $past(st.lamp_ctl[1]) == RMRB_LAMP_ON
    |-> status_lamp_two_out)
    else $error("lamp two dark while on");
  a_lamp_quarter: assert property ($past(st.lamp_ctl[0]) == RMRB_LAMP_QUARTER && $past(st.phase) != 2'h0
    |-> !status_lamp_one_out)
    else $error("quarter lamp lit outside first phase");
  a_lamp_half: assert property ($past(st.lamp_ctl[1]) == RMRB_LAMP_HALF
    |-> status_lamp_two_out == !$past(st.phase[0]))
    else $error("half lamp out of phase");
  a_phase_step: assert property (st.phase != $past(st.phase) |-> $past(half_tick))
    else $error("phase moved off the half second");
  a_scan_rw: assert property (bus_req_in.wr && bus_req_in.addr == RMRB_SCAN_OFS ##1 (bus_req_in.rd
    && bus_req_in.addr == RMRB_SCAN_OFS && !bus_req_in.wr) |=> bus_rdata_out == $past(bus_req_in.wdata, 2))
    else $error("scan code read back wrong");
  a_reserved_zero: assert property (bus_req_in.rd && is_reserved(bus_req_in.addr) |=> bus_rdata_out == 8'h00)
    else $error("reserved read not zero");
  a_either_edge: assert property (either_edge_event_in[3] && $fell(evt_pin_in[3])
    |=> wake_status_out[3] && mgmt_status_out[3] && misc_status_out[3])
    else $error("falling edge lost in either-edge mode");
  a_kbc7_priority: assert property (kbc_port_bit7_sel_a_in && kbc_port_bit7_sel_b_in
    |=> !shared_pin_a_kbc7_out && shared_pin_b_kbc7_out)
    else $error("port bit 7 on both shared pins");
  a_irtx_gate: assert property (!infrared_loc_mux_in |=> !infrared_tx_alt_en_out)
    else $error("infrared alternate enabled without mux");
  a_mgmt_idle: assert property (!mgmt_global_enable_in |=> mgmt_interrupt_o_out || mgmt_interrupt_oe_n_out)
    else $error("management pin active while disabled");
  a_mgmt_pushpull: assert property (!mgmt_open_drain_in && !mgmt_active
    |=> mgmt_interrupt_o_out && !mgmt_interrupt_oe_n_out)
    else $error("idle push-pull management pin not high");
  a_fdc_override: assert property (fdc_select_in && !floppy_mode_reg_in[6] |=> !fdc_pin_oe_n_out)
    else $error("floppy mode bit 6 did not override");
  a_por_status: assert property ($rose(arst_n_in) ##0 st.por_pend |-> wake_status_out[2:0] == 3'h7)
    else $error("power-on status missing");

endmodule : rmrb_bank

/* File: tb/tb_rmrb_bank.sv */
// Self-checking testbench of the runtime miscellaneous register bank.
`timescale 1ns/1ps
module tb_rmrb_bank;
  import rmrb_pkg::*;
  // ====================================================================
  // Stimulus and observed signals.
  localparam int HALF = 8;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  rmrb_bus_req_t req = '0;
  logic [7:0] rdata, d;
  logic [1:0] tach = 2'h0, valid;
  logic lamp1, lamp2;
  logic [3:0] pin = 4'h0, inv = 4'h0, eem = 4'h0, is_in = 4'hF, lvl = 4'h0, clr = 4'h0, men = 4'h0;
  logic [3:0] wake, mgmt, misc, pin_lvl, pin_out;
  logic glob = 1'b0, od = 1'b0, fsel = 1'b0, dd = 1'b0, ctl7 = 1'b0, glvl = 1'b0;
  logic [7:6] fmode = 2'h0;
  logic ka = 1'b0, kb = 1'b0, irm = 1'b0, irs = 1'b0;
  logic mo, moe_n, fo, foe_n, pa, pb, iren;
  int num_errors = 0;
  int check_count = 0;

  // Short blink and tick counts keep the run brief; lamp expectations scale from HALF.
  rmrb_bank #(.HALF_SEC_CYCLES(HALF), .TACH_TICK_CYCLES(2)) i_rmrb_bank (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .bus_req_in(req), .bus_rdata_out(rdata),
    .fan_tach_in(tach), .fan_count_valid_out(valid),
    .status_lamp_one_out(lamp1), .status_lamp_two_out(lamp2),
    .evt_pin_in(pin), .evt_invert_in(inv), .either_edge_event_in(eem), .evt_pin_is_input_in(is_in),
    .evt_out_level_in(lvl), .wake_status_clear_in(clr), .mgmt_status_clear_in(clr),
    .misc_status_clear_in(clr), .wake_status_out(wake), .mgmt_status_out(mgmt),
    .misc_status_out(misc), .evt_pin_level_out(pin_lvl), .evt_pin_is_out_out(pin_out),
    .mgmt_enable_reg_two_in(men), .mgmt_global_enable_in(glob), .mgmt_open_drain_in(od),
    .mgmt_interrupt_o_out(mo), .mgmt_interrupt_oe_n_out(moe_n),
    .fdc_select_in(fsel), .drive_density_function_in(dd), .floppy_mode_reg_in(fmode),
    .gpio_ctl_bit7_in(ctl7), .gpio_level_in(glvl), .fdc_pin_o_out(fo), .fdc_pin_oe_n_out(foe_n),
    .kbc_port_bit7_sel_a_in(ka), .kbc_port_bit7_sel_b_in(kb), .infrared_loc_mux_in(irm),
    .infrared_tx_alt_sel_in(irs), .shared_pin_a_kbc7_out(pa), .shared_pin_b_kbc7_out(pb),
    .infrared_tx_alt_en_out(iren)
  );

  // 200 MHz clock.
  always #2.5 clk_in = ~clk_in;

  // ====================================================================
  // Tasks.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // A write is one strobe cycle; the idle edge after it keeps strobes single.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_in);
    req <= '0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are sampled there.
  task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 d = rdata;
    chk(name, exp, d);
  endtask : rchk

  // Write then read back with no idle cycle: the strobe moves straight from write to read.
  task automatic wr_rchk(input string name, input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    req <= '0;
    #1 d = rdata;
    chk(name, v, d);
  endtask : wr_rchk

  task automatic pulse(input int f);
    @(posedge clk_in);
    tach[f] <= 1'b1;
    tick(2);
    tach[f] <= 1'b0;
    tick(17);
  endtask : pulse

  task automatic clear_all();
    @(posedge clk_in);
    clr <= 4'hF;
    @(posedge clk_in);
    clr <= 4'h0;
    tick(2);
  endtask : clear_all

  // Lit cycles over two whole blink periods do not depend on phase alignment.
  task automatic lamps(input logic [1:0] c1, input logic [1:0] c2);
    logic [7:0] n1, n2;
    logic [7:0] lit [4];
    lit = '{8'h00, 8'(4 * HALF), 8'(2 * HALF), 8'(8 * HALF)};
    wr(RMRB_LAMP_ONE_OFS, {6'h3F, c1});
    wr(RMRB_LAMP_TWO_OFS, {6'h00, c2});
    rchk("lamp one ctl", RMRB_LAMP_ONE_OFS, {6'h00, c1});
    tick(4);
    n1 = 8'h00;
    n2 = 8'h00;
    repeat (8 * HALF) begin
      @(posedge clk_in);
      #1 n1 = n1 + lamp1;
      n2 = n2 + lamp2;
    end
    chk("lamp one lit", lit[c1], n1);
    chk("lamp two lit", lit[c2], n2);
  endtask : lamps

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // ====================================================================
  // Watchdog: the tests need some 500 cycles.
  initial begin
    #100us;
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end

  // ====================================================================
  // Test sequence.
  initial begin
    tick(5);
    chk("pin dir in reset", 8'h0F, pin_out);
    chk("pin lvl in reset", 8'h00, pin_lvl);
    chk("mgmt pin in reset", 8'h03, {mo, moe_n});
    tick(5);
    arst_n_in <= 1'b1;
    tick(3);
    chk("wake por", 8'h07, wake);
    chk("mgmt por", 8'h03, mgmt);
    chk("misc por", 8'h00, misc);
    for (int a = 8'h5B; a <= 8'h5F; a++) begin
      rchk("reg reset", 8'(a), RMRB_REG_RESET);
    end
    wr_rchk("fan one start", RMRB_FAN_ONE_START_OFS, 8'hA5);
    wr(RMRB_FAN_TWO_START_OFS, 8'h3C);
    wr_rchk("scan code", RMRB_SCAN_OFS, 8'h81);
    wr(RMRB_RSVD_LO_OFS, 8'hFF);
    rchk("fan two start", RMRB_FAN_TWO_START_OFS, 8'h3C);
    rchk("rsvd lo", RMRB_RSVD_LO_OFS, 8'h00);
    rchk("rsvd hi", RMRB_RSVD_HI_OFS, 8'h00);
    rchk("unmapped", 8'h40, 8'h00);
    $display("test registers done");
    // Count over about 9 ticks of two cycles from the start value; fan two saturates.
    for (int f = 0; f < 2; f++) begin
      wr(RMRB_FAN_ONE_START_OFS + 8'(f), f ? 8'hFE : 8'h10);
      tick(1);
      chk("valid after start", 8'h00, valid[f]);
      pulse(f);
      pulse(f);
      tick(2);
      chk("valid after two pulses", 8'h01, valid[f]);
      rchk("reading", RMRB_FAN_ONE_COUNT_OFS + 8'(f), f ? 8'hFF : 8'h19);
    end
    $display("test tachometer done");
    lamps(RMRB_LAMP_HALF, RMRB_LAMP_QUARTER);
    lamps(RMRB_LAMP_QUARTER, RMRB_LAMP_HALF);
    lamps(RMRB_LAMP_ON, RMRB_LAMP_OFF);
    lamps(RMRB_LAMP_OFF, RMRB_LAMP_ON);
    $display("test lamps done");
    // Pin 3 either-edge with inversion set; pin 0 single-edge inverted.
    @(posedge clk_in);
    eem <= 4'h8;
    inv <= 4'h9;
    pin <= 4'h9;
    tick(2);
    clear_all();
    chk("wake cleared", 8'h00, wake);
    @(posedge clk_in);
    pin <= 4'h1;
    tick(2);
    chk("wake fall", 8'h08, wake);
    chk("mgmt fall", 8'h08, mgmt);
    chk("misc fall", 8'h08, misc);
    clear_all();
    @(posedge clk_in);
    pin <= 4'h9;
    tick(2);
    chk("misc rise", 8'h08, misc);
    @(posedge clk_in);
    pin <= 4'h8;
    tick(2);
    chk("wake inverted", 8'h09, wake);
    $display("test events done");
    @(posedge clk_in);
    men <= 4'h8;
    tick(2);
    chk("mgmt global off", 8'h02, {mo, moe_n});
    @(posedge clk_in);
    glob <= 1'b1;
    men <= 4'h0;
    tick(2);
    chk("mgmt group off", 8'h02, {mo, moe_n});
    @(posedge clk_in);
    men <= 4'h8;
    od <= 1'b1;
    tick(2);
    chk("mgmt active", 8'h00, {mo, moe_n});
    @(posedge clk_in);
    glob <= 1'b0;
    tick(2);
    chk("mgmt float", 8'h01, moe_n);
    $display("test management pin done");
    @(posedge clk_in);
    fsel <= 1'b1;
    fmode <= 2'h1;
    dd <= 1'b1;
    inv <= 4'h0;
    ka <= 1'b1;
    kb <= 1'b1;
    irs <= 1'b1;
    is_in <= 4'h0;
    lvl <= 4'h5;
    tick(2);
    chk("fdc open drain", 8'h01, foe_n);
    chk("kbc7 pin a", 8'h00, pa);
    chk("kbc7 pin b", 8'h01, pb);
    chk("ir no mux", 8'h00, iren);
    chk("pin out level", 8'h5F, {pin_lvl, pin_out});
    @(posedge clk_in);
    fmode <= 2'h0;
    ctl7 <= 1'b1;
    kb <= 1'b0;
    irm <= 1'b1;
    tick(2);
    chk("fdc push pull", 8'h02, {fo, foe_n});
    chk("kbc7 a alone", 8'h01, pa);
    chk("ir mux", 8'h01, iren);
    @(posedge clk_in);
    fmode <= 2'h2;
    tick(2);
    chk("fdc mode bit7", 8'h00, {fo, foe_n});
    @(posedge clk_in);
    fsel <= 1'b0;
    ctl7 <= 1'b0;
    glvl <= 1'b1;
    tick(2);
    chk("gpio level", 8'h02, {fo, foe_n});
    $display("test pins done");
    // Second reset with every event pin an output: power-on status must not stand.
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    pin <= 4'h0;
    tick(2);
    chk("wake in reset", 8'h07, wake);
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    tick(3);
    chk("wake output pins", 8'h00, wake);
    chk("mgmt output pins", 8'h00, mgmt);
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_rmrb_bank
